// ---- logic/rx_lane_lock_status_monitor.sv ----
// Receive lane lock, FIFO level and alignment status monitor with an
// AXI4-Lite register slave. Lane status pins are asynchronous and are
// synchronised here; the PHY window port is on the core clock.
// Notes on behaviour
// RULE_01: Writing 1 then 0 clears frame errors.
// RULE_02: Frame error count stays zero under lock.
// RULE_03: Per-lane recovered clock lock bits readable.
// RULE_04: Flag select chooses shown FIFO conditions.
// RULE_05: RX full and TX empty/full flag faults.
// RULE_06: Alignment loss drops ready; transmit unaffected.
// RULE_07: Aligned status bit 0 follows ready.
// RULE_08: Link fault enabled: signal loss sets fault.
// RULE_09: Signal loss starts receive digital reset.
// RULE_10: PHY window 0xB0-0xFF maps to +0x400; a PHY write taken in the same cycle as a PHY read is sent to the read address.
// RULE_11: Training and FEC fields target lane 0.
// RULE_12: Count held zero while clear holds 1.
`timescale 1ns/100ps
module rx_lane_lock_status_monitor (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire rx_lock_pkg::lane_pins_t    lanePins,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [rx_lock_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       wvalid,
  output logic                            wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  output logic                            bvalid,
  input  wire logic                       bready,
  output logic [1:0]                      bresp,
  input  wire logic                       arvalid,
  output logic                            arready,
  input  wire logic [rx_lock_pkg::ADDR_W-1:0] araddr,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output rx_lock_pkg::phy_port_t          phyPort,
  input  wire logic [31:0]                phyRdata,
  output logic                            rxPcsReady,
  output logic                            localFaultStatus,
  output logic                            rxDigitalReset,
  output logic                            irq
);
  import rx_lock_pkg::*;

  state_t s;
  state_t n;

  function automatic logic inPhyWindow(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_PHY_LO) && (idx <= IDX_PHY_HI);
  endfunction

  function automatic logic isMapped(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_CLOCK_LOCK, IDX_FRAME_ERR, IDX_FRAME_CLR, IDX_ALIGNED,
      IDX_FLAG_SEL, IDX_FLAGS, IDX_IRQ_STATUS, IDX_IRQ_MASK,
      IDX_CONFIG: return 1'b1;
      default:    return inPhyWindow(idx);
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = val[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Only the groups enabled in the select register are visible.
  function automatic logic [31:0] levelFlags(input state_t st);
    logic [31:0] r;
    r = '0;
    r[0*NUM_LANES +: NUM_LANES] = st.flagSel[SEL_TX_EMPTY] ?
      st.syncB.txEmpty : '0; // RULE_04
    r[1*NUM_LANES +: NUM_LANES] = st.flagSel[SEL_TX_FULL] ?
      st.syncB.txFull : '0;
    r[2*NUM_LANES +: NUM_LANES] = st.flagSel[SEL_RX_EMPTY] ?
      st.syncB.rxEmpty : '0;
    r[3*NUM_LANES +: NUM_LANES] = st.flagSel[SEL_RX_FULL] ?
      st.syncB.rxFull : '0;
    return r;
  endfunction

  function automatic logic [31:0] readReg(input state_t st,
                                          input logic [IDX_W-1:0] idx);
    logic [31:0] r;
    r = '0;
    case (idx)
      IDX_CLOCK_LOCK: r[NUM_LANES-1:0] = st.syncB.cdrLock; // RULE_03
      IDX_FRAME_ERR:  r = st.frameErrCnt;
      IDX_FRAME_CLR:  r[0] = st.frameClr;
      IDX_ALIGNED:    r[0] = st.rxPcsReady; // RULE_07
      IDX_FLAG_SEL:   r[SEL_W-1:0] = st.flagSel;
      IDX_FLAGS:      r = levelFlags(st);
      IDX_IRQ_STATUS: r[IRQ_W-1:0] = st.irqStatus;
      IDX_IRQ_MASK:   r[IRQ_W-1:0] = st.irqMask;
      IDX_CONFIG:     r[0] = st.linkFaultEn;
      default:        r = '0;
    endcase
    return r;
  endfunction

  always_comb begin
    logic [31:0]      wv;
    logic [IRQ_W-1:0] w1c;
    logic [IRQ_W-1:0] ev;
    logic [IDX_W-1:0] ridx;
    logic             readyCond;
    wv   = '0;
    w1c  = '0;
    ev   = '0;
    ridx = araddr[ADDR_W-1:2];
    readyCond = 1'b0;
    n    = s;
    n.syncA  = lanePins;
    n.syncB  = s.syncA;
    n.prev   = s.syncB;
    n.phy.wr = 1'b0;
    n.phy.rd = 1'b0;

    // Write address and data are taken independently, in either order.
    if (awvalid && s.awready) begin
      n.awHeld  = 1'b1;
      n.awIdx   = awaddr[ADDR_W-1:2];
      n.awready = 1'b0;
    end
    if (wvalid && s.wready) begin
      n.wHeld  = 1'b1;
      n.wData  = wdata;
      n.wStrb  = wstrb;
      n.wready = 1'b0;
    end
    if (s.awHeld && s.wHeld && !s.bvalid) begin
      n.awHeld = 1'b0;
      n.wHeld  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = isMapped(s.awIdx) ? RESP_OKAY : RESP_SLVERR;
      wv = merge(readReg(s, s.awIdx), s.wData, s.wStrb);
      case (s.awIdx)
        IDX_FRAME_CLR: n.frameClr    = wv[0];
        IDX_FLAG_SEL:  n.flagSel     = wv[SEL_W-1:0];
        IDX_IRQ_MASK:  n.irqMask     = wv[IRQ_W-1:0];
        IDX_CONFIG:    n.linkFaultEn = wv[0];
        IDX_IRQ_STATUS: begin
          w1c = s.wData[IRQ_W-1:0] & {IRQ_W{s.wStrb[0]}};
        end
        default: begin
          if (inPhyWindow(s.awIdx)) begin
            n.phy.wr    = 1'b1; // RULE_10
            n.phy.addr  = {1'b0, s.awIdx} + PHY_OFFSET;
            n.phy.wdata = s.wData;
            n.phy.lane  = LT_FEC_LANE; // RULE_11
          end
        end
      endcase
    end
    if (s.bvalid && bready) begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end

    // PHY window reads wait one cycle for the returned word.
    if (arvalid && s.arready) begin
      n.arready = 1'b0;
      if (inPhyWindow(ridx)) begin
        n.phy.rd    = 1'b1; // RULE_10
        n.phy.addr  = {1'b0, ridx} + PHY_OFFSET;
        n.phy.lane  = LT_FEC_LANE; // RULE_11
        n.phyRdWait = 1'b1;
      end else begin
        n.rvalid = 1'b1;
        n.rdata  = readReg(s, ridx);
        n.rresp  = isMapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      end
    end
    if (s.phyRdWait) begin
      n.phyRdWait = 1'b0;
      n.rvalid    = 1'b1;
      n.rdata     = phyRdata;
      n.rresp     = RESP_OKAY;
    end
    if (s.rvalid && rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end

    // A held clear forces zero, so counting restarts only after 0 is written.
    if (s.frameClr) begin
      n.frameErrCnt = '0; // RULE_01 RULE_12
    end else if ((|s.syncB.frameErr) && (s.frameErrCnt != '1)) begin
      n.frameErrCnt = s.frameErrCnt + 32'h1; // RULE_02
    end

    // Receive reset restarts on every new loss of signal.
    if (s.syncB.rxLos && !s.prev.rxLos) begin
      n.resetCnt = RX_RESET_CYCLES; // RULE_09
    end else if (s.resetCnt != 8'h0) begin
      n.resetCnt = s.resetCnt - 8'h1;
    end
    n.rxDigReset = (n.resetCnt != 8'h0);

    // Only the receive path is gated; nothing here touches transmit.
    readyCond    = s.syncB.amLock && !s.syncB.rxLos && !n.rxDigReset;
    n.rxPcsReady = readyCond; // RULE_06
    n.linkUp     = s.linkUp | readyCond;
    n.localFault = s.linkFaultEn && s.syncB.rxLos; // RULE_08

    ev[IRQ_RX_FULL]    = |s.syncB.rxFull; // RULE_05
    ev[IRQ_TX_FAULT]   = |(s.syncB.txEmpty | s.syncB.txFull);
    ev[IRQ_ALIGN_LOST] = s.linkUp && s.rxPcsReady && !readyCond;
    ev[IRQ_LOS]        = s.syncB.rxLos && !s.prev.rxLos;
    // A new event in the clearing cycle keeps its bit set.
    n.irqStatus = (s.irqStatus & ~w1c) | ev;
    n.irq       = |(n.irqStatus & n.irqMask);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s             <= '0;
      s.awready     <= 1'b1;
      s.wready      <= 1'b1;
      s.arready     <= 1'b1;
      s.flagSel     <= FLAG_SEL_RST;
      s.irqMask     <= IRQ_MASK_RST;
      s.linkFaultEn <= LINK_FAULT_EN_RST;
      s.phy.lane    <= LT_FEC_LANE;
    end else if (ce) begin
      s <= n;
    end
  end

  assign awready          = s.awready;
  assign wready           = s.wready;
  assign bvalid           = s.bvalid;
  assign bresp            = s.bresp;
  assign arready          = s.arready;
  assign rvalid           = s.rvalid;
  assign rdata            = s.rdata;
  assign rresp            = s.rresp;
  assign phyPort          = s.phy;
  assign rxPcsReady       = s.rxPcsReady;
  assign localFaultStatus = s.localFault;
  assign rxDigitalReset   = s.rxDigReset;
  assign irq              = s.irq;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_clear_zeroes_count: assert property ( // RULE_01
    ce && s.frameClr |=> s.frameErrCnt == 32'h0)
    else $error("Frame error count not zero while clear held.");

  chk_count_quiet_lock: assert property ( // RULE_02
    ce && !s.frameClr && !(|s.syncB.frameErr)
    |=> s.frameErrCnt == $past(s.frameErrCnt))
    else $error("Frame error count moved without an error.");

  chk_lock_bits_read: assert property ( // RULE_03
    ce && arvalid && arready && araddr[ADDR_W-1:2] == IDX_CLOCK_LOCK
    |=> rvalid && rdata[NUM_LANES-1:0] == $past(s.syncB.cdrLock))
    else $error("Clock lock read does not match lane lock bits.");

  chk_rx_full_fault: assert property ( // RULE_05
    ce && (|s.syncB.rxFull) |=> s.irqStatus[IRQ_RX_FULL])
    else $error("Receive FIFO full did not set its status bit.");

  chk_ready_drops: assert property ( // RULE_06
    ce && !s.syncB.amLock |=> !rxPcsReady)
    else $error("Ready stayed high after alignment loss.");

  chk_aligned_bit: assert property ( // RULE_07
    ce && arvalid && arready && araddr[ADDR_W-1:2] == IDX_ALIGNED
    |=> rvalid && rdata[0] == $past(rxPcsReady))
    else $error("Aligned status bit differs from ready.");

  chk_local_fault: assert property ( // RULE_08
    ce && s.linkFaultEn && s.syncB.rxLos |=> localFaultStatus)
    else $error("Local fault not raised on loss of signal.");

  chk_los_reset: assert property ( // RULE_09
    ce && s.syncB.rxLos && !s.prev.rxLos
    |=> rxDigitalReset && s.resetCnt == RX_RESET_CYCLES)
    else $error("Receive reset not started on loss of signal.");

  chk_phy_window: assert property ( // RULE_10
    ce && arvalid && arready && inPhyWindow(araddr[ADDR_W-1:2])
    |=> phyPort.rd
        && phyPort.addr == {1'b0, $past(araddr[ADDR_W-1:2])} + PHY_OFFSET
    ##1 rvalid)
    else $error("PHY window read not forwarded with offset.");

  chk_lane_zero: assert property ( // RULE_11
    phyPort.rd || phyPort.wr |-> phyPort.lane == LT_FEC_LANE)
    else $error("PHY access not aimed at lane zero.");
endmodule

// ---- logic/rx_lock_pkg.sv ----
// Package for the receive lane lock and alignment status monitor.
// Assumes a single 100 MHz core clock and a 32-bit AXI4-Lite register bus.
package rx_lock_pkg;
  localparam int NUM_LANES = 4;
  localparam int ADDR_W    = 12;
  localparam int IDX_W     = 10;
  localparam int IRQ_W     = 4;
  localparam int SEL_W     = 4;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CLOCK_LOCK = 10'h321;
  localparam logic [IDX_W-1:0] IDX_FRAME_ERR  = 10'h323;
  localparam logic [IDX_W-1:0] IDX_FRAME_CLR  = 10'h324;
  localparam logic [IDX_W-1:0] IDX_ALIGNED    = 10'h326;
  localparam logic [IDX_W-1:0] IDX_FLAG_SEL   = 10'h328;
  localparam logic [IDX_W-1:0] IDX_FLAGS      = 10'h329;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h32A;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h32B;
  localparam logic [IDX_W-1:0] IDX_CONFIG     = 10'h32C;
  localparam logic [IDX_W-1:0] IDX_PHY_LO     = 10'h0B0;
  localparam logic [IDX_W-1:0] IDX_PHY_HI     = 10'h0FF;
  localparam logic [10:0]      PHY_OFFSET     = 11'h400;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Interrupt status and mask bit positions.
  localparam int IRQ_RX_FULL    = 0;
  localparam int IRQ_TX_FAULT   = 1;
  localparam int IRQ_ALIGN_LOST = 2;
  localparam int IRQ_LOS        = 3;

  // Flag select bit positions, one per FIFO condition group.
  localparam int SEL_TX_EMPTY = 0;
  localparam int SEL_TX_FULL  = 1;
  localparam int SEL_RX_EMPTY = 2;
  localparam int SEL_RX_FULL  = 3;

  localparam logic [SEL_W-1:0] FLAG_SEL_RST = 4'hF;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic             LINK_FAULT_EN_RST = 1'b0;
  localparam logic [1:0]       LT_FEC_LANE  = 2'h0;

  localparam int         CLK_PERIOD_NS = 10;
  localparam int         RX_RESET_NS   = 160;
  localparam logic [7:0] RX_RESET_CYCLES =
    8'(RX_RESET_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic [NUM_LANES-1:0] cdrLock;
    logic [NUM_LANES-1:0] frameErr;
    logic [NUM_LANES-1:0] txEmpty;
    logic [NUM_LANES-1:0] txFull;
    logic [NUM_LANES-1:0] rxEmpty;
    logic [NUM_LANES-1:0] rxFull;
    logic                 amLock;
    logic                 rxLos;
  } lane_pins_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  lane;
    logic [10:0] addr;
    logic [31:0] wdata;
  } phy_port_t;

  typedef struct packed {
    lane_pins_t       syncA;
    lane_pins_t       syncB;
    lane_pins_t       prev;
    logic             awHeld;
    logic [IDX_W-1:0] awIdx;
    logic             wHeld;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             phyRdWait;
    phy_port_t        phy;
    logic             frameClr;
    logic [31:0]      frameErrCnt;
    logic [SEL_W-1:0] flagSel;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqMask;
    logic             linkFaultEn;
    logic             linkUp;
    logic             rxPcsReady;
    logic             localFault;
    logic [7:0]       resetCnt;
    logic             rxDigReset;
    logic             irq;
  } state_t;
endpackage

// ---- sim/phy_reg_model.sv ----
// Model of the backplane PHY register block behind the forwarding port.
// Assumes one clock; read data stands in the strobe cycle and the next.
`timescale 1ns/100ps
module phy_reg_model (
  input  wire logic                   core_clk,
  input  wire rx_lock_pkg::phy_port_t phyPort,
  output logic [31:0]                 phyRdata
);
  import rx_lock_pkg::*;

  logic [31:0] mem [logic [10:0]];
  logic [31:0] last = 32'h0;
  logic        hold = 1'b0;

  // Only lane 0 owns training and FEC fields; other lanes read garbage.
  function automatic logic [31:0] ans(phy_port_t p);
    if (p.lane !== LT_FEC_LANE) return 32'hDEAD0000;
    if (mem.exists(p.addr)) return mem[p.addr];
    return {21'h0, p.addr} ^ 32'hC3C30000;
  endfunction

  always @(posedge core_clk) begin
    if (phyPort.wr && phyPort.lane === LT_FEC_LANE) begin
      mem[phyPort.addr] = phyPort.wdata;
    end
    hold <= phyPort.rd;
    last <= phyPort.rd ? ans(phyPort) : ~last;
  end

  // Outside an answer the bus toggles so stale data cannot pass.
  assign phyRdata = phyPort.rd ? ans(phyPort) : (hold ? last : ~last);
endmodule

// ---- sim/rx_lane_lock_status_monitor_tb.sv ----
// Self-checking bench for the lane lock status monitor.
// Assumes the PHY register model on the forwarding port, one clock.
`timescale 1ns/100ps
module rx_lane_lock_status_monitor_tb;
  import rx_lock_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  lane_pins_t lanePins = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, phyRdata, rdv, seed = 32'h41C75304;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid;
  logic rxPcsReady, localFaultStatus, rxDigitalReset, irq;
  phy_port_t phyPort;
  int nTests = 0, miscompares = 0, n;

  always #5 core_clk = ~core_clk;

  rx_lane_lock_status_monitor i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .ce(ce), .lanePins(lanePins), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .phyPort(phyPort),
    .phyRdata(phyRdata), .rxPcsReady(rxPcsReady),
    .localFaultStatus(localFaultStatus), .rxDigitalReset(rxDigitalReset),
    .irq(irq));
  phy_reg_model i_phy (.core_clk(core_clk), .phyPort(phyPort),
    .phyRdata(phyRdata));

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [11:0] ba(logic [IDX_W-1:0] i);
    return {i, 2'b00};
  endfunction
  function automatic logic [31:0] flagsExp(logic [3:0] s, lane_pins_t p);
    return {16'h0, p.rxFull & {4{s[3]}}, p.rxEmpty & {4{s[2]}},
            p.txFull & {4{s[1]}}, p.txEmpty & {4{s[0]}}};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // Both channels are offered together and each is dropped when taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rdv = rdata;
    resp = rresp;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    results();
  end

  initial begin
    cyc(5);
    rst_n <= 1'b1;
    rd(ba(IDX_FLAG_SEL));
    chk(rdv, {28'h0, FLAG_SEL_RST});
    rd(ba(IDX_IRQ_MASK));
    chk(rdv, {28'h0, IRQ_MASK_RST});
    rd(12'h000);
    chk(rdv, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(12'h000, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(ba(IDX_CLOCK_LOCK), 32'hFFFFFFFF);
    chk(resp, RESP_OKAY);
    repeat (4) begin
      seed = xs(seed);
      lanePins.cdrLock <= seed[3:0];
      cyc(4);
      rd(ba(IDX_CLOCK_LOCK));
      chk(rdv, {28'h0, seed[3:0]});
    end
    $display("test map and clock lock done");
    n = 1 + int'(seed[8:4]);
    lanePins.frameErr <= 4'h1;
    cyc(n);
    lanePins.frameErr <= 4'h0;
    cyc(4);
    rd(ba(IDX_FRAME_ERR));
    chk(rdv, 32'(n));
    wr(ba(IDX_FRAME_CLR), 32'h1);
    rd(ba(IDX_FRAME_ERR));
    chk(rdv, 32'h0);
    lanePins.frameErr <= 4'hF;
    cyc(5);
    lanePins.frameErr <= 4'h0;
    cyc(4);
    rd(ba(IDX_FRAME_ERR));
    chk(rdv, 32'h0);
    wr(ba(IDX_FRAME_CLR), 32'h0);
    rd(ba(IDX_FRAME_ERR));
    chk(rdv, 32'h0);
    lanePins.frameErr <= 4'h8;
    cyc(3);
    lanePins.frameErr <= 4'h0;
    cyc(4);
    rd(ba(IDX_FRAME_ERR));
    chk(rdv, 32'h3);
    // Errors seen only while the clock enable is low must not count.
    ce <= 1'b0;
    lanePins.frameErr <= 4'h1;
    cyc(5);
    lanePins.frameErr <= 4'h0;
    cyc(2);
    ce <= 1'b1;
    cyc(4);
    rd(ba(IDX_FRAME_ERR));
    chk(rdv, 32'h3);
    $display("test frame errors done");
    seed = xs(seed);
    {lanePins.txEmpty, lanePins.txFull, lanePins.rxEmpty,
     lanePins.rxFull} <= seed[15:0];
    cyc(4);
    for (int s = 0; s < 16; s++) begin
      wr(ba(IDX_FLAG_SEL), 32'(s));
      rd(ba(IDX_FLAGS));
      chk(rdv, flagsExp(4'(s), lanePins));
    end
    // Without the byte 0 strobe the select register keeps its value.
    wstrb <= 4'hE;
    wr(ba(IDX_FLAG_SEL), 32'h0);
    wstrb <= 4'hF;
    rd(ba(IDX_FLAG_SEL));
    chk(rdv, 32'hF);
    {lanePins.txEmpty, lanePins.txFull, lanePins.rxEmpty,
     lanePins.rxFull} <= 16'h0;
    cyc(4);
    wr(ba(IDX_IRQ_STATUS), 32'hF);
    wr(ba(IDX_IRQ_MASK), 32'h1);
    lanePins.rxFull <= 4'h4;
    cyc(5);
    chk(irq, 1'b1);
    lanePins.rxFull <= 4'h0;
    lanePins.rxEmpty <= 4'hF;
    cyc(4);
    wr(ba(IDX_IRQ_STATUS), 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    lanePins.txEmpty <= 4'h2;
    cyc(5);
    rd(ba(IDX_IRQ_STATUS));
    chk(rdv, 32'h2);
    chk(irq, 1'b0);
    $display("test fifo flags done");
    lanePins.txEmpty <= 4'h0;
    lanePins.rxEmpty <= 4'h0;
    lanePins.amLock <= 1'b1;
    cyc(5);
    chk(rxPcsReady, 1'b1);
    rd(ba(IDX_ALIGNED));
    chk(rdv, 32'h1);
    wr(ba(IDX_CONFIG), 32'h1);
    lanePins.rxLos <= 1'b1;
    lanePins.amLock <= 1'b0;
    n = 0;
    while (!rxDigitalReset && n < 10) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (rxDigitalReset && n < 40) begin
      cyc(1);
      n++;
    end
    chk(32'(n), 32'(RX_RESET_CYCLES));
    chk(localFaultStatus, 1'b1);
    chk(rxPcsReady, 1'b0);
    rd(ba(IDX_ALIGNED));
    chk(rdv, 32'h0);
    rd(ba(IDX_IRQ_STATUS));
    chk(rdv & 32'hC, 32'hC);
    wr(ba(IDX_CONFIG), 32'h0);
    cyc(2);
    chk(localFaultStatus, 1'b0);
    $display("test signal loss done");
    seed = xs(seed);
    wr(12'h2C0, seed);
    rd(12'h2C0);
    chk(rdv, seed);
    rd(12'h3FC);
    chk(rdv, 32'h000004FF ^ 32'hC3C30000);
    $display("test phy window done");
    results();
  end
endmodule
